// [spm_regs.vh]
`ifndef SPM_REGS_VH
`define SPM_REGS_VH
// ----------------------------------------
// Register offsets (register port index)
// ----------------------------------------
`define SPM_OFS_CTRL 3'h0
`define SPM_OFS_CFG 3'h1
`define SPM_OFS_EPS 3'h2
`define SPM_OFS_DATA 3'h3
`define SPM_OFS_IRQ 3'h4
`define SPM_OFS_PULL 3'h5
// ----------------------------------------
// Field positions
// ----------------------------------------
`define SPM_CTRL_EN 0
`define SPM_CTRL_OWN 1
`define SPM_CFG_WS_LO 0
`define SPM_CFG_WS_HI 3
`define SPM_CFG_FIRST_STROBE_PIN_ENABLE 4
`define SPM_CFG_CHIP_SELECT_PIN_ENABLE 5
`define SPM_CFG_SCH_LO 6
`define SPM_CFG_SCH_HI 7
`define SPM_EPS_ADDR_LO 0
`define SPM_EPS_ADDR_HI 3
`define SPM_EPS_BUSY 4
`define SPM_EPS_WR 6
`define SPM_EPS_RD 7
`define SPM_IRQ_FLAG 0
`define SPM_IRQ_EN 1
`define SPM_IRQ_PRIO 2
`define SPM_PULL_EN 0
// ----------------------------------------
// Reset values
// ----------------------------------------
`define SPM_RST_CTRL 2'h0
`define SPM_RST_CFG 8'h00
`define SPM_RST_ADDR 4'h0
`define SPM_RST_DATA 8'h00
// ----------------------------------------
// Strobe schemes and timing
// ----------------------------------------
`define SPM_SCH_ADDR_DATA 2'h0
`define SPM_SCH_WR_RD 2'h1
`define SPM_INSTR_DIV 2'h3
`endif

// [spm_streaming_port.v]
`timescale 1ns/10ps
`include "spm_regs.vh"
// Contract
// - Port drives two strobes, an output-enable strobe and a chip select.
// - Strobe assignment selectable: address/data, write/read, or odd/even endpoint.
// - First strobe and chip select each released when their enable is off.
// - Wait states count in source clock cycles: USB clock or instruction clock.
// - Four-bit wait field adds zero to thirty waits in steps of two.
// - Half the waits follow each of the two base cycles.
// - Data lines get pull-ups switched by a dedicated enable bit.
// - Under USB ownership stream endpoint address first, then data bytes.
// - Under processor ownership the transfer clock is the instruction clock.
// - Processor mode sets completion flag per operation; enable and priority bits.
// - Writing endpoint address register starts an address cycle in address mode.
// - Writing the data register starts a data write cycle with that byte.
// - Busy stays high through a cycle and its waits, low when ready.
// - Data read returns previous byte, starts new read, then holds new byte.
// - Low four bits of the status register hold the endpoint address.
// - Bit 7 reports last USB byte was read, bit 6 last USB byte was write.
// - Scheme field: 1x odd/even, 01 write/read, 00 address/data.
// - Ownership bit one gives USB control, zero gives processor control.
// - Wait field value times two is the number of extra waits.
module spm_streaming_port #(
   parameter WS_W = 4
) (
   input wire clk, // System clock, 125 MHz
   input wire rstn, // Async reset, active low
   input wire [2:0] reg_addr, // Register index
   input wire [7:0] reg_wdata, // Register write data
   input wire reg_wr, // Register write strobe
   input wire reg_rd, // Register read strobe
   output reg [7:0] reg_rdata, // Read data, cycle after read
   input wire usb_clk, // USB clock, sampled
   input wire usb_req, // USB engine wants a byte moved
   input wire usb_first, // First byte of a packet
   input wire usb_is_read, // Byte direction: read from slave
   input wire [3:0] usb_ep, // Endpoint of this packet
   input wire [7:0] usb_wdata, // Byte to write
   output reg usb_done, // Byte moved, one pulse
   output reg [7:0] usb_rdata, // Byte read from slave
   input wire [7:0] data_in, // Data lines, input
   output reg [7:0] data_out, // Data lines, output
   output wire data_oe, // Data lines driven
   output wire data_pullup_en, // Data line pull-ups on
   output wire first_strobe_out, // First strobe level
   output wire first_strobe_oe, // First strobe pin driven
   output wire second_strobe_out, // Second strobe level
   output wire output_enable_strobe_n, // Slave output enable, low
   output wire chip_select_out_n, // Chip select, low
   output wire chip_select_oe, // Chip select pin driven
   output wire completion_irq, // Gated completion request
   output wire completion_irq_high // Request at high priority
);

   // ----------------------------------------
   // States and declarations
   // ----------------------------------------
   localparam ST_IDLE = 3'h0;
   localparam ST_ARM = 3'h1;
   localparam ST_P1 = 3'h2;
   localparam ST_W1 = 3'h3;
   localparam ST_P2 = 3'h4;
   localparam ST_W2 = 3'h5;

   reg [2:0] state_reg;
   reg [WS_W-1:0] cnt_reg;
   reg [1:0] ctrl_reg;
   reg [7:0] cfg_reg;
   reg [3:0] ep_reg;
   reg [7:0] data_reg;
   reg last_rd_reg;
   reg last_wr_reg;
   reg irq_flag_reg;
   reg irq_en_reg;
   reg irq_prio_reg;
   reg pull_reg;
   reg cyc_addr_reg;
   reg cyc_read_reg;
   reg cyc_usb_reg;
   reg data_pend_reg;
   reg [1:0] div_reg;
   reg [2:0] uclk_sync;
   reg uclk_lvl;
   reg uclk_lvl_d;
   reg [7:0] din_s1;
   reg [7:0] din_s2;
   reg [7:0] din_s3;
   reg [7:0] din_f;

   wire port_en = ctrl_reg[`SPM_CTRL_EN];
   wire owned_usb = ctrl_reg[`SPM_CTRL_OWN];
   wire [WS_W-1:0] ws_half = cfg_reg[`SPM_CFG_WS_HI:`SPM_CFG_WS_LO];
   wire [1:0] scheme = cfg_reg[`SPM_CFG_SCH_HI:`SPM_CFG_SCH_LO];
   wire busy = (state_reg != ST_IDLE);
   wire active = (state_reg != ST_IDLE) && (state_reg != ST_ARM);
   wire strobe_on = (state_reg == ST_P1) || (state_reg == ST_W1);
   wire proc_tick = (div_reg == `SPM_INSTR_DIV);
   wire usb_tick = uclk_lvl & ~uclk_lvl_d;
   wire proc_owned_ok;
   wire wr_eps;
   wire wr_data;
   wire rd_data;
   wire usb_go;

   // ----------------------------------------
   // Strobe selection
   // ----------------------------------------
   // Picks which strobe fires for a cycle; address cycles count as writes
   function strobe_is_first;
      input [1:0] sch;
      input is_addr;
      input is_read;
      input [3:0] ep;
      begin
         if (sch[1]) begin
            strobe_is_first = ep[0];
         end else if (sch == `SPM_SCH_WR_RD) begin
            strobe_is_first = ~is_read;
         end else begin
            strobe_is_first = is_addr;
         end
      end
   endfunction

   wire sel_first = strobe_is_first(scheme, cyc_addr_reg, cyc_read_reg, ep_reg);

   // ----------------------------------------
   // Source clock enables
   // ----------------------------------------
   // Instruction clock is a divide by four of the system clock
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         div_reg <= 2'h0;
      end else begin
         div_reg <= div_reg + 2'h1;
      end
   end

   // USB clock: three stages, level moves only when stages two and three agree
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         uclk_sync <= 3'h0;
         uclk_lvl <= 1'b0;
         uclk_lvl_d <= 1'b0;
      end else begin
         uclk_sync <= {uclk_sync[1:0], usb_clk};
         if (uclk_sync[1] == uclk_sync[2]) begin
            uclk_lvl <= uclk_sync[2];
         end
         uclk_lvl_d <= uclk_lvl;
      end
   end

   // Waits run on the clock of whoever owns the port
   wire tick = owned_usb ? usb_tick : proc_tick;

   // Data pins come from outside, so they are synchronised the same way
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         din_s1 <= 8'h00;
         din_s2 <= 8'h00;
         din_s3 <= 8'h00;
         din_f <= 8'h00;
      end else begin
         din_s1 <= data_in;
         din_s2 <= din_s1;
         din_s3 <= din_s2;
         if (din_s2 == din_s3) begin
            din_f <= din_s3;
         end
      end
   end

   // ----------------------------------------
   // Request decode
   // ----------------------------------------
   // Requests made while busy are dropped; firmware is expected to poll
   assign proc_owned_ok = port_en && !owned_usb && !busy;
   assign wr_eps = reg_wr && (reg_addr == `SPM_OFS_EPS);
   assign wr_data = reg_wr && (reg_addr == `SPM_OFS_DATA);
   assign rd_data = reg_rd && (reg_addr == `SPM_OFS_DATA);
   assign usb_go = port_en && owned_usb && !busy && usb_req && !usb_done;

   // Last cycle of a transaction: end of second half with its waits
   wire cyc_end = tick && (((state_reg == ST_P2) && (ws_half == {WS_W{1'b0}})) ||
                             ((state_reg == ST_W2) && (cnt_reg == {{(WS_W-1){1'b0}}, 1'b1})));

   // ----------------------------------------
   // Transaction sequencer
   // ----------------------------------------
   // ARM waits for a source clock edge so the first base cycle is whole
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_reg <= ST_IDLE;
         cnt_reg <= {WS_W{1'b0}};
         cyc_addr_reg <= 1'b0;
         cyc_read_reg <= 1'b0;
         cyc_usb_reg <= 1'b0;
         data_pend_reg <= 1'b0;
         data_out <= 8'h00;
      end else if (!port_en) begin
         state_reg <= ST_IDLE;
         data_pend_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (usb_go) begin
                  state_reg <= ST_ARM;
                  cyc_usb_reg <= 1'b1;
                  cyc_addr_reg <= usb_first;
                  cyc_read_reg <= usb_is_read & ~usb_first;
                  data_pend_reg <= usb_first;
                  data_out <= usb_first ? {4'h0, usb_ep} : usb_wdata;
               end else if (proc_owned_ok && wr_eps && (scheme == `SPM_SCH_ADDR_DATA)) begin
                  state_reg <= ST_ARM;
                  cyc_usb_reg <= 1'b0;
                  cyc_addr_reg <= 1'b1;
                  cyc_read_reg <= 1'b0;
                  data_out <= {4'h0, reg_wdata[`SPM_EPS_ADDR_HI:`SPM_EPS_ADDR_LO]};
               end else if (proc_owned_ok && wr_data) begin
                  state_reg <= ST_ARM;
                  cyc_usb_reg <= 1'b0;
                  cyc_addr_reg <= 1'b0;
                  cyc_read_reg <= 1'b0;
                  data_out <= reg_wdata;
               end else if (proc_owned_ok && rd_data) begin
                  state_reg <= ST_ARM;
                  cyc_usb_reg <= 1'b0;
                  cyc_addr_reg <= 1'b0;
                  cyc_read_reg <= 1'b1;
               end
            end
            ST_ARM: begin
               if (tick) begin
                  state_reg <= ST_P1;
               end
            end
            ST_P1: begin
               if (tick) begin
                  cnt_reg <= ws_half;
                  state_reg <= (ws_half == {WS_W{1'b0}}) ? ST_P2 : ST_W1;
               end
            end
            ST_W1: begin
               if (tick) begin
                  cnt_reg <= cnt_reg - {{(WS_W-1){1'b0}}, 1'b1};
                  if (cnt_reg == {{(WS_W-1){1'b0}}, 1'b1}) begin
                     state_reg <= ST_P2;
                  end
               end
            end
            ST_P2: begin
               if (tick) begin
                  cnt_reg <= ws_half;
                  state_reg <= (ws_half == {WS_W{1'b0}}) ? ST_IDLE : ST_W2;
               end
            end
            ST_W2: begin
               if (tick) begin
                  cnt_reg <= cnt_reg - {{(WS_W-1){1'b0}}, 1'b1};
                  if (cnt_reg == {{(WS_W-1){1'b0}}, 1'b1}) begin
                     state_reg <= ST_IDLE;
                  end
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         // Address done under USB: the data byte follows straight away
         if (cyc_end && cyc_usb_reg && data_pend_reg) begin
            state_reg <= ST_ARM;
            data_pend_reg <= 1'b0;
            cyc_addr_reg <= 1'b0;
            cyc_read_reg <= usb_is_read;
            data_out <= usb_wdata;
         end
      end
   end

   // ----------------------------------------
   // Completion effects
   // ----------------------------------------
   // Read data is taken as the transaction ends: slave still drives, sync has settled
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         data_reg <= `SPM_RST_DATA;
         usb_rdata <= 8'h00;
         usb_done <= 1'b0;
         last_rd_reg <= 1'b0;
         last_wr_reg <= 1'b0;
         irq_flag_reg <= 1'b0;
      end else begin
         usb_done <= cyc_end && cyc_usb_reg && !data_pend_reg;
         if (cyc_end && cyc_read_reg) begin
            if (cyc_usb_reg) begin
               usb_rdata <= din_f;
            end else begin
               data_reg <= din_f;
            end
         end else if (wr_data && proc_owned_ok) begin
            data_reg <= reg_wdata;
         end
         if (cyc_end && cyc_usb_reg) begin
            last_rd_reg <= cyc_read_reg;
            last_wr_reg <= ~cyc_read_reg;
         end
         // Set beats a same-cycle clear so no completion is lost
         if (cyc_end && !cyc_usb_reg) begin
            irq_flag_reg <= 1'b1;
         end else if (reg_wr && reg_addr == `SPM_OFS_IRQ && !reg_wdata[`SPM_IRQ_FLAG]) begin
            irq_flag_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // Register writes
   // ----------------------------------------
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ctrl_reg <= `SPM_RST_CTRL;
         cfg_reg <= `SPM_RST_CFG;
         ep_reg <= `SPM_RST_ADDR;
         irq_en_reg <= 1'b0;
         irq_prio_reg <= 1'b0;
         pull_reg <= 1'b0;
      end else if (reg_wr) begin
         case (reg_addr)
            `SPM_OFS_CTRL: begin
               ctrl_reg <= reg_wdata[1:0];
            end
            `SPM_OFS_CFG: begin
               cfg_reg <= reg_wdata;
            end
            `SPM_OFS_EPS: begin
               ep_reg <= reg_wdata[`SPM_EPS_ADDR_HI:`SPM_EPS_ADDR_LO];
            end
            `SPM_OFS_IRQ: begin
               irq_en_reg <= reg_wdata[`SPM_IRQ_EN];
               irq_prio_reg <= reg_wdata[`SPM_IRQ_PRIO];
            end
            `SPM_OFS_PULL: begin
               pull_reg <= reg_wdata[`SPM_PULL_EN];
            end
            default: begin
               pull_reg <= pull_reg;
            end
         endcase
      end else if (usb_go && usb_first) begin
         ep_reg <= usb_ep;
      end
   end

   // ----------------------------------------
   // Register reads
   // ----------------------------------------
   // Read data only valid the cycle after the strobe; unmapped reads zero
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         case (reg_addr)
            `SPM_OFS_CTRL: reg_rdata <= {6'h00, ctrl_reg};
            `SPM_OFS_CFG: reg_rdata <= cfg_reg;
            `SPM_OFS_EPS: reg_rdata <= {last_rd_reg, last_wr_reg, 1'b0, busy, ep_reg};
            `SPM_OFS_DATA: reg_rdata <= data_reg;
            `SPM_OFS_IRQ: reg_rdata <= {5'h00, irq_prio_reg, irq_en_reg, irq_flag_reg};
            `SPM_OFS_PULL: reg_rdata <= {7'h00, pull_reg};
            default: reg_rdata <= 8'h00;
         endcase
      end else begin
         reg_rdata <= 8'h00;
      end
   end

   // ----------------------------------------
   // Pin drive
   // ----------------------------------------
   // Strobes high in the first base cycle and its waits only
   assign first_strobe_out = strobe_on & sel_first;
   assign second_strobe_out = strobe_on & ~sel_first;
   assign output_enable_strobe_n = ~(active & cyc_read_reg);
   assign chip_select_out_n = ~active;
   assign first_strobe_oe = port_en & cfg_reg[`SPM_CFG_FIRST_STROBE_PIN_ENABLE];
   assign chip_select_oe = port_en & cfg_reg[`SPM_CFG_CHIP_SELECT_PIN_ENABLE];
   assign data_oe = active & ~cyc_read_reg;
   assign data_pullup_en = pull_reg;
   assign completion_irq = irq_flag_reg & irq_en_reg;
   assign completion_irq_high = irq_flag_reg & irq_en_reg & irq_prio_reg;

endmodule

// [spm_slave_model.sv]
`timescale 1ns/10ps
// Slave device on the far side: answers reads, logs bytes per strobe
module spm_slave_model (
   input wire clk, // Port clock, used to find strobe edges
   input wire [7:0] data_out, // Master data drive
   input wire data_oe, // Master drives the lines
   input wire data_pullup_en, // Line pull-ups on
   input wire first_strobe_out, // First strobe level
   input wire second_strobe_out, // Second strobe level
   input wire output_enable_strobe_n, // Slave may drive, low
   input wire [7:0] rd_val, // Byte this slave answers with
   output wire [7:0] data_in, // Resolved data lines
   output reg [7:0] wr_first, // Byte seen as first strobe fell
   output reg [7:0] wr_second, // Byte seen as second strobe fell
   output reg [1:0] last_sel // Strobe that ended last, {second, first}
);
   reg [7:0] last_reg = 8'h00;
   reg s1_reg = 1'b0;
   reg s2_reg = 1'b0;
   // Released lines never hold old data: pull-up or a moving pattern
   assign data_in = data_oe ? data_out : (!output_enable_strobe_n ? rd_val :
      (data_pullup_en ? 8'hFF : ~last_reg));
   // A FIFO clocks the byte in as the strobe drops
   always @(posedge clk) begin
      last_reg <= data_in;
      s1_reg <= first_strobe_out;
      s2_reg <= second_strobe_out;
      if (s1_reg && !first_strobe_out) begin
         wr_first <= data_in;
         last_sel <= 2'h1;
      end
      if (s2_reg && !second_strobe_out) begin
         wr_second <= data_in;
         last_sel <= 2'h2;
      end
   end
endmodule

// [spm_streaming_port_checker.sv]
`timescale 1ns/10ps
// Port-side timing relations; strobe and select run on tick multiples
module spm_port_checker (
   input wire clk, // System clock
   input wire rstn, // Async reset, active low
   input wire reg_rd, // Register read strobe
   input wire [7:0] reg_rdata, // Register read data
   input wire usb_done, // USB byte finished
   input wire data_oe, // Data lines driven
   input wire first_strobe_out, // First strobe
   input wire second_strobe_out, // Second strobe
   input wire output_enable_strobe_n, // Slave output enable, low
   input wire chip_select_out_n, // Chip select, low
   input wire completion_irq, // Gated completion request
   input wire completion_irq_high // High priority request
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
      else $error("read data not zero outside read answer");
   a_irq_prio_gated: assert property (completion_irq_high |-> completion_irq)
      else $error("high priority request without request");
   a_strobes_exclusive: assert property (!(first_strobe_out && second_strobe_out))
      else $error("both strobes high");
   a_strobe_in_cs: assert property ((first_strobe_out || second_strobe_out)
      |-> !chip_select_out_n)
      else $error("strobe outside chip select");
   a_drive_in_cs: assert property (data_oe |-> !chip_select_out_n)
      else $error("data driven outside chip select");
   a_read_no_drive: assert property (!output_enable_strobe_n |-> !data_oe)
      else $error("master drives while slave enabled");
   a_strobe_tick_hold: assert property ($rose(first_strobe_out)
      |-> first_strobe_out [*4])
      else $error("first strobe shorter than one tick");
   a_cs_two_ticks: assert property ($fell(chip_select_out_n)
      |-> !chip_select_out_n [*8])
      else $error("chip select shorter than two base cycles");
   a_done_one_pulse: assert property (usb_done |=> !usb_done)
      else $error("usb done longer than one cycle");
endmodule
bind spm_streaming_port spm_port_checker i_chk (.clk(clk), .rstn(rstn), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .usb_done(usb_done), .data_oe(data_oe),
   .first_strobe_out(first_strobe_out), .second_strobe_out(second_strobe_out),
   .output_enable_strobe_n(output_enable_strobe_n), .chip_select_out_n(chip_select_out_n),
   .completion_irq(completion_irq), .completion_irq_high(completion_irq_high));

// [tb_spm_streaming_port.sv]
`timescale 1ns/10ps
`include "spm_regs.vh"
module tb_spm_streaming_port;
   reg clk = 1'b0;
   reg rstn = 1'b0;
   reg usb_clk = 1'b0;
   reg [2:0] reg_addr = 3'h0;
   reg [7:0] reg_wdata = 8'h00;
   reg reg_wr = 1'b0;
   reg reg_rd = 1'b0;
   reg usb_req = 1'b0;
   reg usb_first = 1'b0;
   reg usb_is_read = 1'b0;
   reg [3:0] usb_ep = 4'h0;
   reg [7:0] usb_wdata = 8'h00;
   reg [7:0] rd_val = 8'h00;
   reg [7:0] v;
   wire [7:0] reg_rdata, usb_rdata, data_in, data_out, wr_first, wr_second;
   wire [1:0] last_sel;
   wire usb_done, data_oe, data_pullup_en, first_strobe_out, first_strobe_oe;
   wire second_strobe_out, output_enable_strobe_n, chip_select_out_n, chip_select_oe;
   wire completion_irq, completion_irq_high;
   integer fail_count = 0;
   integer tests_run = 0;
   integer cs_cnt = 0;
   integer s1_cnt = 0;
   integer c0, c1, ws;
   // Clocks; the link clock is offset so its edges never line up with clk
   always #4 clk = ~clk;
   initial #1.3 forever #32 usb_clk = ~usb_clk;
   // Cycle counts of select and first strobe
   always @(posedge clk) begin
      if (chip_select_out_n === 1'b0) cs_cnt = cs_cnt + 1;
      if (first_strobe_out === 1'b1) s1_cnt = s1_cnt + 1;
   end
   spm_streaming_port i_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .usb_clk(usb_clk), .usb_req(usb_req), .usb_first(usb_first),
      .usb_is_read(usb_is_read), .usb_ep(usb_ep), .usb_wdata(usb_wdata),
      .usb_done(usb_done), .usb_rdata(usb_rdata), .data_in(data_in), .data_out(data_out),
      .data_oe(data_oe), .data_pullup_en(data_pullup_en),
      .first_strobe_out(first_strobe_out), .first_strobe_oe(first_strobe_oe),
      .second_strobe_out(second_strobe_out), .output_enable_strobe_n(output_enable_strobe_n),
      .chip_select_out_n(chip_select_out_n), .chip_select_oe(chip_select_oe),
      .completion_irq(completion_irq), .completion_irq_high(completion_irq_high));
   spm_slave_model i_slave (.clk(clk), .data_out(data_out), .data_oe(data_oe),
      .data_pullup_en(data_pullup_en), .first_strobe_out(first_strobe_out),
      .second_strobe_out(second_strobe_out), .output_enable_strobe_n(output_enable_strobe_n),
      .rd_val(rd_val), .data_in(data_in), .wr_first(wr_first), .wr_second(wr_second),
      .last_sel(last_sel));
   // ----------------------------------------
   // Bus tasks
   // ----------------------------------------
   task end_of_test;
      begin
         $display("tests_run=%0d fail_count=%0d", tests_run, fail_count);
         if (fail_count == 0 && tests_run > 0) $display("All tests passed");
         else $display("Some tests failed");
         $finish;
      end
   endtask
   task chk(input [95:0] nm, input [7:0] e, input [7:0] g);
      begin
         tests_run = tests_run + 1;
         if (g !== e) begin
            fail_count = fail_count + 1;
            $display("ERROR %0s expected %h seen %h", nm, e, g);
         end
      end
   endtask
   task wr(input [2:0] a, input [7:0] d);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= 1'b1;
         @(posedge clk);
         reg_wr <= 1'b0;
         #1;
      end
   endtask
   // Read data stands only in the cycle after the strobe
   task rd(input [2:0] a, output [7:0] d);
      begin
         @(posedge clk);
         reg_addr <= a;
         reg_rd <= 1'b1;
         @(posedge clk);
         reg_rd <= 1'b0;
         #1 d = reg_rdata;
      end
   endtask
   task rdc(input [2:0] a, input [7:0] e, input [95:0] nm);
      begin
         rd(a, v);
         chk(nm, e, v);
      end
   endtask
   // Poll busy the way firmware must before the next request
   task wait_idle;
      integer n;
      begin
         v = 8'hFF;
         for (n = 0; n < 400 && v[`SPM_EPS_BUSY] !== 1'b0; n = n + 1)
            rd(`SPM_OFS_EPS, v);
         if (v[`SPM_EPS_BUSY] !== 1'b0) begin
            fail_count = fail_count + 1;
            end_of_test;
         end
      end
   endtask
   // The engine drops its request on the edge that ends the done cycle, so nothing retriggers
   task wait_done;
      integer n;
      begin
         for (n = 0; n < 2000 && usb_done !== 1'b1; n = n + 1) begin
            @(posedge clk);
            #1;
         end
         @(posedge clk);
         usb_req <= 1'b0;
         if (usb_done !== 1'b1) begin
            fail_count = fail_count + 1;
            end_of_test;
         end
      end
   endtask
   initial begin
      #600000;
      fail_count = fail_count + 1;
      end_of_test;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      rdc(`SPM_OFS_CTRL, 8'h00, "ctrl");
      rdc(`SPM_OFS_CFG, 8'h00, "cfg");
      rdc(`SPM_OFS_EPS, 8'h00, "eps");
      rdc(3'h7, 8'h00, "unmapped");
      wr(`SPM_OFS_CTRL, 8'h01);
      chk("strobe1 oe", 8'h00, {7'h0, first_strobe_oe});
      chk("cs oe", 8'h00, {7'h0, chip_select_oe});
      wr(`SPM_OFS_PULL, 8'h01);
      @(posedge clk);
      #1 chk("pullup", 8'h01, {7'h0, data_pullup_en});
      wr(`SPM_OFS_CFG, 8'h30);
      chk("strobe1 oe", 8'h01, {7'h0, first_strobe_oe});
      chk("cs oe", 8'h01, {7'h0, chip_select_oe});
      wr(`SPM_OFS_IRQ, 8'h06);
      // Address cycle, then data cycle, address/data scheme
      wr(`SPM_OFS_EPS, 8'h05);
      rdc(`SPM_OFS_EPS, 8'h15, "eps busy");
      wait_idle;
      chk("addr byte", 8'h05, wr_first);
      chk("irq", 8'h01, {7'h0, completion_irq_high});
      wr(`SPM_OFS_IRQ, 8'h02);
      chk("irq clear", 8'h00, {7'h0, completion_irq});
      wr(`SPM_OFS_DATA, 8'hA5);
      wait_idle;
      chk("data byte", 8'hA5, wr_second);
      chk("irq again", 8'h01, {7'h0, completion_irq});
      // Wait states, write/read scheme, counted in instruction ticks
      for (ws = 0; ws < 16; ws = ws + 5) begin
         wr(`SPM_OFS_CFG, 8'h70 | ws[7:0]);
         c0 = cs_cnt;
         c1 = s1_cnt;
         wr(`SPM_OFS_DATA, 8'h11 + ws[7:0]);
         wait_idle;
         chk("cs cycles", 8'((2 + 2 * ws) * (`SPM_INSTR_DIV + 1)), 8'(cs_cnt - c0));
         chk("s1 cycles", 8'((1 + ws) * (`SPM_INSTR_DIV + 1)), 8'(s1_cnt - c1));
         chk("write strobe", 8'h11 + ws[7:0], wr_first);
      end
      // Data read returns the byte of the cycle before
      wr(`SPM_OFS_CFG, 8'h70);
      rd_val <= 8'h3C;
      rdc(`SPM_OFS_DATA, 8'h20, "data old");
      wait_idle;
      chk("read strobe", 8'h02, {6'h0, last_sel});
      rd_val <= 8'hC3;
      rdc(`SPM_OFS_DATA, 8'h3C, "data read1");
      wait_idle;
      rdc(`SPM_OFS_DATA, 8'hC3, "data read2");
      wait_idle;
      // Odd endpoints on the first strobe, even on the second
      wr(`SPM_OFS_CFG, 8'hB0);
      for (ws = 2; ws < 4; ws = ws + 1) begin
         wr(`SPM_OFS_EPS, ws[7:0]);
         wr(`SPM_OFS_DATA, 8'h40 + ws[7:0]);
         wait_idle;
         chk("odd even", (ws == 3) ? 8'h01 : 8'h02, {6'h0, last_sel});
      end
      // USB ownership: endpoint first, then the byte
      wr(`SPM_OFS_CFG, 8'h30);
      wr(`SPM_OFS_CTRL, 8'h02);
      wr(`SPM_OFS_CTRL, 8'h03);
      // A single isochronous endpoint streams through the port
      @(posedge clk);
      usb_ep <= 4'h9;
      usb_wdata <= 8'h5A;
      usb_first <= 1'b1;
      usb_req <= 1'b1;
      wait_done;
      chk("usb addr", 8'h09, wr_first);
      chk("usb data", 8'h5A, wr_second);
      rd(`SPM_OFS_EPS, v);
      chk("last write", 8'h40, v & 8'hC0);
      @(posedge clk);
      rd_val <= 8'h77;
      usb_first <= 1'b0;
      usb_is_read <= 1'b1;
      usb_req <= 1'b1;
      wait_done;
      chk("usb read", 8'h77, usb_rdata);
      rd(`SPM_OFS_EPS, v);
      chk("last read", 8'h80, v & 8'hC0);
      end_of_test;
   end
endmodule
